//--- rtl/gph_defines.svh
// register offsets, field positions, command values and reset values of the host port
`ifndef GPH_DEFINES_SVH
`define GPH_DEFINES_SVH
// port register selects, write side
`define GPH_W_DATA_OUT    3'h0
`define GPH_W_INT_EN1     3'h1
`define GPH_W_INT_EN2     3'h2
`define GPH_W_ADDR_MODE   3'h4
`define GPH_W_AUX_MODE    3'h5
`define GPH_W_ADDRESS     3'h6
`define GPH_W_EOS         3'h7
// port register selects, read side
`define GPH_R_DATA_IN     3'h0
`define GPH_R_INT_ST1     3'h1
`define GPH_R_INT_ST2     3'h2
`define GPH_R_ADDR_ST     3'h4
`define GPH_R_ADDRESS     3'h6
`define GPH_R_EOS         3'h7
// field positions
`define GPH_ST1_BI        0
`define GPH_ST1_BO        1
`define GPH_ST1_END       4
`define GPH_ST2_ADDRESS_CHANGE_FLAG      0
`define GPH_IE2_DMA_IN_ENABLE      4
`define GPH_IE2_DMA_OUT_ENABLE      5
`define GPH_AST_LA        2
`define GPH_AST_TA        1
`define GPH_AST_TON       6
`define GPH_AST_LON       7
`define GPH_AUXA_EOS      2
// command values
`define GPH_AUX_PON       8'h00
`define GPH_AUX_RESET     8'h02
`define GPH_AUX_EOI_EOS   8'h84
`define GPH_AUX_CLK_NIB   4'h2
`define GPH_AUX_A_TOP     3'h4
`define GPH_MODE_ONE      8'h01
`define GPH_MODE_TON      8'h80
`define GPH_MODE_LON      8'h40
`define GPH_IE_NONE       8'h00
`define GPH_CMD_LISTEN    3'h1
`define GPH_CMD_TALK      3'h2
`define GPH_CMD_UNL       8'h3F
`define GPH_CMD_UNT       8'h5F
`define GPH_CLK_RESET     4'h8
// controller register word offsets on the avalon side
`define GPH_AV_CTRL       3'h0
`define GPH_AV_PORT       3'h1
`define GPH_AV_TX         3'h2
`define GPH_AV_RX         3'h3
`define GPH_AV_CFG        3'h4
`define GPH_INIT_STEPS    4'h9
`endif

//--- rtl/gph_dev.sv
// talker/listener end: register port, dma request logic and a byte-level bus model
// Function
// R1 - request when out or in flag enabled
// R2 - status read clears bits, not request flops
// R3 - acknowledge forces select lines to zero
// R4 - acknowledged strobe drops the request
// R5 - input: flag, request, read, then ready
// R6 - output: flag, request, write, then valid
// R7 - host re-reads status, redirects dma
// R8 - init on reset or aux 02H
// R9 - zero enables disable interrupts and dma
// R10 - address mode 01H, 80H, 40H
// R11 - aux 2x loads clock in MHz
// R12 - aux 84H sends end with eos byte
// R13 - aux 00H releases init, idle till attention
// R14 - matching listen or talk address addresses us
// R15 - host writes zero top three address bits
// R16 - address change sets change flag
// R17 - status shows talker and listener roles
// R18 - end flag on end-or-identify or eos match
// R19 - talk-only raises out flag at release
// R20 - end-or-identify only as block end
// R21 - init clears status, keeps enables
// R22 - without acknowledge decode select lines
module gph_dev
  import gph_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // processor port
  gph_port_if.dev         port,
  // bus acceptor side
  input  wire logic       bus_valid,
  input  wire logic [7:0] bus_byte,
  input  wire logic       bus_eoi,
  input  wire logic       bus_atn,
  output logic            bus_rfd,
  // bus source side
  output logic            src_valid,
  output logic [7:0]      src_byte,
  output logic            src_eoi,
  input  wire logic       src_ack
);
`include "gph_defines.svh"

  logic       eff_cs_n;
  logic [2:0] eff_rs;
  logic       rd_acc;
  logic       wr_acc;
  logic       init_q;
  logic [7:0] ie1_q;
  logic [7:0] ie2_q;
  logic [7:0] mode_q;
  logic [4:0] aux_a_q;
  logic [3:0] clk_mhz_q;
  logic [4:0] my_addr_q;
  logic [7:0] eos_q;
  logic [7:0] din_q;
  logic [7:0] dout_q;
  logic       bi_ff_q;
  logic       bo_ff_q;
  logic       st_bi_q;
  logic       st_bo_q;
  logic       st_end_q;
  logic       st_address_change_flag_q;
  logic       ta_q;
  logic       la_q;
  logic       ta_d;
  logic       la_d;
  logic       pend_q;
  logic [3:0] settle_q;
  logic [7:0] rdata_q;
  logic       take_cmd;
  logic       take_data;
  logic       talker;
  logic       listener;
  logic       eos_hit;

  // acknowledge overrides whatever the processor puts on the select lines
  assign eff_cs_n = port.dma_acknowledge_n ? port.cs_n : 1'b0; // R3 R22
  assign eff_rs   = port.dma_acknowledge_n ?
                    {port.register_select_hi, port.register_select_mid, port.register_select_lo} : 3'h0; // R3 R22
  assign rd_acc   = !eff_cs_n && !port.rd_n;
  assign wr_acc   = !eff_cs_n && !port.wr_n;

  function automatic logic wr_to(input logic [2:0] sel);
    wr_to = wr_acc && (eff_rs == sel);
  endfunction
  function automatic logic rd_of(input logic [2:0] sel);
    rd_of = rd_acc && (eff_rs == sel);
  endfunction

  // modes
  assign talker   = !init_q && (ta_q || mode_q == `GPH_MODE_TON);  // R10
  assign listener = !init_q && (la_q || mode_q == `GPH_MODE_LON);  // R10
  // attention bytes are commands; eoi with attention belongs to the controller chip
  assign take_cmd  = bus_valid && bus_atn && !init_q;              // R13 R20
  assign take_data = bus_valid && !bus_atn && listener && bus_rfd;
  assign eos_hit   = aux_a_q[`GPH_AUXA_EOS] && (bus_byte == eos_q);
  assign bus_rfd   = !bi_ff_q && !init_q;                          // R5

  // init state: entered on reset pin or aux 02H, left on aux 00H
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_q <= 1'b1;                                              // R8
    end else if (wr_to(`GPH_W_AUX_MODE) && port.wdata == `GPH_AUX_RESET) begin
      init_q <= 1'b1;                                              // R8
    end else if (wr_to(`GPH_W_AUX_MODE) && port.wdata == `GPH_AUX_PON) begin
      init_q <= 1'b0;                                              // R13
    end
  end

  // enables survive the reset command; only the pin clears them
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ie1_q <= 8'h00;
      ie2_q <= 8'h00;
    end else begin
      if (wr_to(`GPH_W_INT_EN1)) begin
        ie1_q <= port.wdata;                                       // R9 R21
      end
      if (wr_to(`GPH_W_INT_EN2)) begin
        ie2_q <= port.wdata;                                       // R9 R21
      end
    end
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q    <= 8'h00;
      aux_a_q   <= 5'h00;
      clk_mhz_q <= `GPH_CLK_RESET;
      my_addr_q <= 5'h00;
      eos_q     <= 8'h00;
    end else begin
      if (wr_to(`GPH_W_ADDR_MODE)) begin
        mode_q <= port.wdata;                                      // R10
      end
      if (wr_to(`GPH_W_AUX_MODE)) begin
        if (port.wdata == `GPH_AUX_RESET) begin
          aux_a_q   <= 5'h00;
          clk_mhz_q <= `GPH_CLK_RESET;
        end else if (port.wdata[7:4] == `GPH_AUX_CLK_NIB) begin
          clk_mhz_q <= port.wdata[3:0];                            // R11
        end else if (port.wdata[7:5] == `GPH_AUX_A_TOP) begin
          aux_a_q <= port.wdata[4:0];                              // R12
        end
      end
      if (wr_to(`GPH_W_ADDRESS)) begin
        my_addr_q <= port.wdata[4:0];                              // R15
      end
      if (wr_to(`GPH_W_EOS)) begin
        eos_q <= port.wdata;
      end
    end
  end

  // addressing from attention commands
  always_comb begin
    ta_d = ta_q;
    la_d = la_q;
    if (init_q) begin
      ta_d = 1'b0;
      la_d = 1'b0;
    end else if (take_cmd) begin
      if (bus_byte[7:5] == `GPH_CMD_LISTEN && bus_byte[4:0] == my_addr_q) begin
        la_d = 1'b1;                                               // R14
      end else if (bus_byte == `GPH_CMD_UNL) begin
        la_d = 1'b0;
      end
      if (bus_byte[7:5] == `GPH_CMD_TALK) begin
        ta_d = (bus_byte[4:0] == my_addr_q);                       // R14
      end else if (bus_byte == `GPH_CMD_UNT) begin
        ta_d = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ta_q <= 1'b0;
      la_q <= 1'b0;
    end else begin
      ta_q <= ta_d;                                                // R17
      la_q <= la_d;                                                // R17
    end
  end

  // request flops: cleared by the data transfer itself, by init and, for the out flag, when not talker; not by status reads
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bi_ff_q <= 1'b0;
      bo_ff_q <= 1'b0;
      din_q   <= 8'h00;
    end else begin
      if (init_q || (rd_of(`GPH_R_DATA_IN) && !take_data)) begin
        bi_ff_q <= 1'b0;                                           // R5
      end else if (take_data) begin
        bi_ff_q <= 1'b1;                                           // R5
        din_q   <= bus_byte;
      end
      if (!talker || wr_to(`GPH_W_DATA_OUT)) begin
        bo_ff_q <= 1'b0;                                           // R6
      end else if (!pend_q && !src_valid) begin
        bo_ff_q <= 1'b1;                                           // R19
      end
    end
  end

  // source side: settle for clk_mhz cycles after the write, then present the byte
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q    <= 1'b0;
      settle_q  <= 4'h0;
      dout_q    <= 8'h00;
      src_valid <= 1'b0;
      src_byte  <= 8'h00;
      src_eoi   <= 1'b0;
    end else if (init_q) begin
      pend_q    <= 1'b0;
      src_valid <= 1'b0;
    end else if (wr_to(`GPH_W_DATA_OUT) && bo_ff_q) begin
      pend_q   <= 1'b1;                                            // R6
      settle_q <= clk_mhz_q;                                       // R11
      dout_q   <= port.wdata;
    end else if (pend_q) begin
      if (settle_q == 4'h0) begin
        pend_q    <= 1'b0;
        src_valid <= 1'b1;                                         // R6
        src_byte  <= dout_q;
        src_eoi   <= aux_a_q[`GPH_AUXA_EOS] && (dout_q == eos_q);  // R12 R20
      end else begin
        settle_q <= settle_q - 4'h1;
      end
    end else if (src_valid && src_ack) begin
      src_valid <= 1'b0;
      src_eoi   <= 1'b0;
    end
  end

  // sticky status: a new event wins over the read that clears it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_bi_q   <= 1'b0;
      st_bo_q   <= 1'b0;
      st_end_q  <= 1'b0;
      st_address_change_flag_q <= 1'b0;
    end else if (init_q) begin
      st_bi_q   <= 1'b0;                                           // R21
      st_bo_q   <= 1'b0;                                           // R21
      st_end_q  <= 1'b0;                                           // R21
      st_address_change_flag_q <= 1'b0;                                           // R21
    end else begin
      if (take_data) begin
        st_bi_q  <= 1'b1;
        st_end_q <= bus_eoi || eos_hit;                            // R18
      end else if (rd_of(`GPH_R_INT_ST1)) begin
        st_bi_q  <= 1'b0;                                          // R2
        st_end_q <= 1'b0;
      end
      if (talker && !bo_ff_q && !pend_q && !src_valid && !wr_to(`GPH_W_DATA_OUT)) begin
        st_bo_q <= 1'b1;                                           // R19
      end else if (rd_of(`GPH_R_INT_ST1)) begin
        st_bo_q <= 1'b0;                                           // R2
      end
      if ((ta_d != ta_q) || (la_d != la_q)) begin
        st_address_change_flag_q <= 1'b1;                                         // R16
      end else if (rd_of(`GPH_R_INT_ST2)) begin
        st_address_change_flag_q <= 1'b0;
      end
    end
  end

  // read data latched at the strobe; host takes it one cycle later
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (rd_acc) begin
      unique case (eff_rs)
        `GPH_R_DATA_IN: rdata_q <= din_q;
        `GPH_R_INT_ST1: rdata_q <= {3'h0, st_end_q, 2'h0, st_bo_q, st_bi_q};
        `GPH_R_INT_ST2: rdata_q <= {7'h00, st_address_change_flag_q};
        `GPH_R_ADDR_ST: rdata_q <= {mode_q == `GPH_MODE_LON, mode_q == `GPH_MODE_TON, 3'h0,
                                    la_q, ta_q, 1'b0};                // R17
        `GPH_R_ADDRESS: rdata_q <= {3'h0, my_addr_q};
        `GPH_R_EOS:     rdata_q <= eos_q;
        default:        rdata_q <= 8'h00;
      endcase
    end
  end

  assign port.rdata = rdata_q;
  // combinational so the acknowledged strobe removes the request at once
  assign port.dma_request = ((bo_ff_q && ie2_q[`GPH_IE2_DMA_OUT_ENABLE]) || (bi_ff_q && ie2_q[`GPH_IE2_DMA_IN_ENABLE])) // R1 R9
                            && !(!port.dma_acknowledge_n && (!port.rd_n || !port.wr_n));      // R4
  assign port.irq = |({st_end_q, st_bo_q, st_bi_q} & {ie1_q[`GPH_ST1_END], ie1_q[`GPH_ST1_BO], ie1_q[`GPH_ST1_BI]})
                    || (st_address_change_flag_q && ie2_q[`GPH_ST2_ADDRESS_CHANGE_FLAG]);          // R9
endmodule

//--- rtl/gph_host.sv
// controller end: avalon-mm registers, init sequencer and dma engine driving the port
module gph_host
  import gph_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // processor port
  gph_port_if.host         port
);
`include "gph_defines.svh"

  gph_port_state_t st_q;
  gph_src_t        src_q;
  logic [1:0]  ctrl_q;
  logic [31:0] cfg_q;
  logic        sw_req_q;
  logic        sw_rd_q;
  logic [2:0]  sw_rs_q;
  logic [7:0]  sw_data_q;
  logic [7:0]  sw_rdata_q;
  logic [3:0]  step_q;
  logic        init_run_q;
  logic [7:0]  tx_q;
  logic        tx_full_q;
  logic [7:0]  rx_q;
  logic        rx_full_q;
  logic        rd_done_q;
  logic        acc_rd_q;
  logic [2:0]  acc_rs_q;
  logic [7:0]  acc_data_q;
  logic        dma_go;
  logic [10:0] step_op;
  logic        busy;

  // init sequence: reset, quiet enables, mode, clock, address, eos, eoi-on-eos, release
  function automatic logic [10:0] init_op(input logic [3:0] n, input logic [31:0] cfg);
    unique case (n)
      4'd0:    init_op = {`GPH_W_AUX_MODE, `GPH_AUX_RESET};                       // R8
      4'd1:    init_op = {`GPH_W_INT_EN1, `GPH_IE_NONE};                          // R9
      4'd2:    init_op = {`GPH_W_INT_EN2, `GPH_IE_NONE};                          // R9
      4'd3:    init_op = {`GPH_W_ADDR_MODE, cfg[15:8]};                           // R10
      4'd4:    init_op = {`GPH_W_AUX_MODE, `GPH_AUX_CLK_NIB, cfg[19:16]};         // R11
      4'd5:    init_op = {`GPH_W_ADDRESS, 3'h0, cfg[4:0]};                        // R15
      4'd6:    init_op = {`GPH_W_EOS, cfg[31:24]};
      4'd7:    init_op = {`GPH_W_AUX_MODE, `GPH_AUX_EOI_EOS};                     // R12
      default: init_op = {`GPH_W_AUX_MODE, `GPH_AUX_PON};                         // R13
    endcase
  endfunction

  assign step_op = init_op(step_q, cfg_q);
  assign busy    = sw_req_q || (st_q != GPH_PS_IDLE);
  // direction comes from software, which sets it after reading address status
  assign dma_go  = ctrl_q[1] && port.dma_request &&
                   (ctrl_q[0] ? tx_full_q : !rx_full_q);            // R7
  assign avs_waitrequest = (avs_read && !rd_done_q) ||
                           (avs_write && avs_address == `GPH_AV_PORT && busy);

  // avalon registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 2'h0;
      cfg_q  <= {8'h0D, 4'h0, `GPH_CLK_RESET, `GPH_MODE_ONE, 8'h00};
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == `GPH_AV_CTRL) begin
        ctrl_q <= avs_writedata[2:1];                               // R7
      end
      if (avs_address == `GPH_AV_CFG) begin
        cfg_q <= avs_writedata;
      end
    end
  end

  // software single access and init trigger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_req_q   <= 1'b0;
      sw_rd_q    <= 1'b0;
      sw_rs_q    <= 3'h0;
      sw_data_q  <= 8'h00;
      init_run_q <= 1'b0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == `GPH_AV_PORT) begin
        sw_req_q  <= 1'b1;
        sw_rd_q   <= avs_writedata[11];
        sw_rs_q   <= avs_writedata[10:8];
        sw_data_q <= (avs_writedata[10:8] == `GPH_W_ADDRESS && !avs_writedata[11]) ?
                     {3'h0, avs_writedata[4:0]} : avs_writedata[7:0];  // R15
      end else if (st_q == GPH_PS_IDLE && !init_run_q) begin
        sw_req_q <= 1'b0;
      end
      if (avs_write && !avs_waitrequest && avs_address == `GPH_AV_CTRL && avs_writedata[0]) begin
        init_run_q <= 1'b1;                                         // R8
      end else if (st_q == GPH_PS_IDLE && step_q == `GPH_INIT_STEPS) begin
        init_run_q <= 1'b0;
      end
    end
  end

  // port engine: one strobe cycle, then one cycle to take latched read data
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= GPH_PS_IDLE;
      src_q      <= GPH_SRC_SW;
      acc_rd_q   <= 1'b0;
      acc_rs_q   <= 3'h0;
      acc_data_q <= 8'h00;
      step_q     <= 4'h0;
      sw_rdata_q <= 8'h00;
    end else begin
      unique case (st_q)
        GPH_PS_IDLE: begin
          if (init_run_q && step_q != `GPH_INIT_STEPS) begin
            st_q       <= GPH_PS_STROBE;
            src_q      <= GPH_SRC_INIT;
            acc_rd_q   <= 1'b0;
            {acc_rs_q, acc_data_q} <= step_op;
            step_q     <= step_q + 4'h1;
          end else if (!init_run_q && sw_req_q) begin
            st_q       <= GPH_PS_STROBE;
            src_q      <= GPH_SRC_SW;
            acc_rd_q   <= sw_rd_q;
            acc_rs_q   <= sw_rs_q;
            acc_data_q <= sw_data_q;
          end else if (!init_run_q && dma_go) begin
            st_q       <= GPH_PS_STROBE;                            // R5 R6
            src_q      <= GPH_SRC_DMA;
            acc_rd_q   <= !ctrl_q[0];
            acc_rs_q   <= 3'h0;
            acc_data_q <= tx_q;
          end
          if (!init_run_q) begin
            step_q <= 4'h0;
          end
        end
        GPH_PS_STROBE: st_q <= GPH_PS_TAKE;
        GPH_PS_TAKE: begin
          st_q <= GPH_PS_IDLE;
          if (src_q == GPH_SRC_SW && acc_rd_q) begin
            sw_rdata_q <= port.rdata;
          end
        end
        default: st_q <= GPH_PS_IDLE;
      endcase
    end
  end

  // one-byte dma buffers toward software
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q      <= 8'h00;
      tx_full_q <= 1'b0;
      rx_q      <= 8'h00;
      rx_full_q <= 1'b0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == `GPH_AV_TX && !tx_full_q) begin
        tx_q      <= avs_writedata[7:0];
        tx_full_q <= 1'b1;
      end else if (st_q == GPH_PS_TAKE && src_q == GPH_SRC_DMA && !acc_rd_q) begin
        tx_full_q <= 1'b0;                                          // R6
      end
      if (st_q == GPH_PS_TAKE && src_q == GPH_SRC_DMA && acc_rd_q) begin
        rx_q      <= port.rdata;                                    // R5
        rx_full_q <= 1'b1;
      end else if (avs_read && !avs_waitrequest && avs_address == `GPH_AV_RX) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // registered read answer: waitrequest for exactly one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_done_q    <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_done_q <= avs_read && !rd_done_q;
      if (avs_read && !rd_done_q) begin
        unique case (avs_address)
          `GPH_AV_CTRL: avs_readdata <= {29'h0, ctrl_q, init_run_q};
          `GPH_AV_PORT: avs_readdata <= {21'h0, port.irq, port.dma_request, busy, sw_rdata_q};
          `GPH_AV_TX:   avs_readdata <= {23'h0, tx_full_q, tx_q};
          `GPH_AV_RX:   avs_readdata <= {23'h0, rx_full_q, rx_q};
          `GPH_AV_CFG:  avs_readdata <= cfg_q;
          default:      avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // port pins: strobes are low only in the strobe state
  assign port.cs_n  = !(st_q == GPH_PS_STROBE && src_q != GPH_SRC_DMA);
  assign port.dma_acknowledge_n = !(st_q == GPH_PS_STROBE && src_q == GPH_SRC_DMA);
  assign port.rd_n  = !(st_q == GPH_PS_STROBE && acc_rd_q);
  assign port.wr_n  = !(st_q == GPH_PS_STROBE && !acc_rd_q);
  assign port.register_select_lo  = acc_rs_q[0];
  assign port.register_select_mid = acc_rs_q[1];
  assign port.register_select_hi  = acc_rs_q[2];
  assign port.wdata = acc_data_q;
endmodule

//--- rtl/gph_pkg.sv
// types shared by both ends of the host port
package gph_pkg;
  typedef enum logic [1:0] {
    GPH_PS_IDLE   = 2'b00,
    GPH_PS_STROBE = 2'b01,
    GPH_PS_TAKE   = 2'b10
  } gph_port_state_t;
  typedef enum logic [1:0] {
    GPH_SRC_SW   = 2'b00,
    GPH_SRC_INIT = 2'b01,
    GPH_SRC_DMA  = 2'b10
  } gph_src_t;
endpackage

//--- rtl/gph_port_if.sv
// the parallel microprocessor-side port joining controller and talker/listener
interface gph_port_if;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       register_select_lo;
  logic       register_select_mid;
  logic       register_select_hi;
  logic       dma_acknowledge_n;
  logic       dma_request;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       irq;
  modport dev (input cs_n, rd_n, wr_n, register_select_lo, register_select_mid, register_select_hi,
               dma_acknowledge_n, wdata, output dma_request, rdata, irq);
  modport host (output cs_n, rd_n, wr_n, register_select_lo, register_select_mid, register_select_hi,
                dma_acknowledge_n, wdata, input dma_request, rdata, irq);
endinterface

//--- tb/gph_port_asserts.sv
// concurrent checks on the host port between controller and talker/listener
module gph_port_asserts (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_n,
  // strobes and selects
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       register_select_lo,
  input wire logic       register_select_mid,
  input wire logic       register_select_hi,
  input wire logic       dma_acknowledge_n,
  // device answers
  input wire logic       dma_request,
  input wire logic [7:0] rdata
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic stb;
  assign stb = !rd_n || !wr_n;
  chk_ack_drops_req: assert property (!dma_acknowledge_n && stb |-> !dma_request)
    else $error("request high in acknowledged strobe");
  chk_req_stays_low: assert property (!dma_acknowledge_n && stb |=> !dma_request)
    else $error("request back right after acknowledged strobe");
  chk_ack_sel_zero: assert property (!dma_acknowledge_n && stb |-> !register_select_lo && !register_select_mid && !register_select_hi)
    else $error("select bits set under acknowledge");
  chk_ack_on_req: assert property ($fell(dma_acknowledge_n) |-> $past(dma_request))
    else $error("acknowledge without request");
  chk_strobe_spacing: assert property (stb |=> !stb ##1 !stb)
    else $error("strobe too wide or too close");
  chk_strobe_sel: assert property (stb |-> (cs_n ^ dma_acknowledge_n) && (rd_n ^ wr_n))
    else $error("strobe with bad select");
  chk_rdata_stands: assert property ($past(rd_n) |-> $stable(rdata))
    else $error("read data moved without read");
  chk_req_rise_free: assert property ($rose(dma_request) |-> dma_acknowledge_n)
    else $error("request rose under acknowledge");
endmodule

//--- tb/gpib_host_dma_port_tb.sv
// self-checking bench: controller and talker/listener joined at the host port
module gpib_host_dma_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [2:0]  avs_address = 0;
  logic [31:0] avs_writedata = 0, avs_readdata, rd_q;
  logic        bus_valid = 0, bus_eoi = 0, bus_atn = 0, bus_rfd, src_valid, src_eoi, src_ack = 0;
  logic [7:0]  bus_byte = 0, src_byte;
  int          bad_count = 0, total_checks = 0;
  logic [2:0]  sel_tab [7] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [7:0]  exp_tab [7] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0D};
  gph_port_if port_if();
  gph_host i_gph_host(.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .port(port_if));
  gph_dev i_gph_dev(.sys_clk, .rst_n, .port(port_if), .bus_valid, .bus_byte, .bus_eoi, .bus_atn,
    .bus_rfd, .src_valid, .src_byte, .src_eoi, .src_ack);
  gph_port_asserts i_gph_port_asserts(.sys_clk, .rst_n, .cs_n(port_if.cs_n), .rd_n(port_if.rd_n),
    .wr_n(port_if.wr_n), .register_select_lo(port_if.register_select_lo),
    .register_select_mid(port_if.register_select_mid), .register_select_hi(port_if.register_select_hi),
    .dma_acknowledge_n(port_if.dma_acknowledge_n), .dma_request(port_if.dma_request), .rdata(port_if.rdata));
  always #12.5 sys_clk = ~sys_clk;
  task cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // request held until waitrequest is seen low at an edge
  task av(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd_q = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge sys_clk);
  endtask
  task poll(input logic [2:0] a, input int b, input logic v);
    do av(0, a, 0); while (rd_q[b] !== v);
  endtask
  // one port access, then wait until the engine is idle
  task prt(input logic [11:0] c);
    av(1, 3'h1, {20'h0, c});
    poll(3'h1, 8, 0);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #500us;
    bad_count++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    cmp({port_if.cs_n, port_if.rd_n, port_if.wr_n, port_if.dma_request, port_if.irq, bus_rfd}, 6'h38);
    rst_n <= 1;
    av(0, 3'h4, 0);
    cmp(rd_q, 32'h0D080100);
    av(1, 3'h0, 1);
    poll(3'h0, 0, 0);
    cmp(bus_rfd, 1);
    foreach (sel_tab[i]) begin
      prt({1'h1, sel_tab[i], 8'h0});
      cmp(rd_q[7:0], exp_tab[i]);
    end
    bus_valid <= 1;
    bus_atn <= 1;
    bus_byte <= 8'h20;
    @(posedge sys_clk);
    bus_valid <= 0;
    bus_atn <= 0;
    prt(12'hC00);
    cmp(rd_q[7:0], 8'h04);
    prt(12'hA00);
    cmp(rd_q[0], 1'h1);
    prt(12'h210);
    av(1, 3'h0, 4);
    bus_valid <= 1;
    bus_byte <= 8'hA5;
    bus_eoi <= 1;
    do @(posedge sys_clk); while (bus_rfd !== 1'b1);
    bus_valid <= 0;
    bus_eoi <= 0;
    poll(3'h3, 8, 1);
    cmp(rd_q[8:0], 9'h1A5);
    prt(12'h900);
    cmp(rd_q[4], 1'h1);
    av(1, 3'h4, 32'h0D088000);
    av(1, 3'h0, 3);
    poll(3'h0, 0, 0);
    prt(12'h900);
    cmp(rd_q[1], 1'h1);
    cmp(port_if.dma_request, 0);
    prt(12'h220);
    cmp(port_if.dma_request, 1'h1);
    av(1, 3'h0, 6);
    av(1, 3'h2, 8'h0D);
    do @(posedge sys_clk); while (src_valid !== 1'b1);
    cmp({src_eoi, src_byte}, 9'h10D);
    src_ack <= 1;
    @(posedge sys_clk);
    src_ack <= 0;
    repeat (3) @(posedge sys_clk);
    cmp(port_if.dma_request, 1'h1);
    prt(12'h6FF);
    cmp(port_if.wdata, 8'h1F);
    print_verdict;
  end
endmodule
